// file: sim/mcu_reset_sequencer_test.sv
// Self-checking bench for the reset sequencer and its cause register.
// Assumes the APB port, the CPU strobes and the pin model share clk.
`timescale 1ns/1ps
module mcu_reset_sequencer_test;
  logic clk, srst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic por_det, lowv_det, ext_hold, rst_pin_in, mon_mode, err;
  logic [6:0] ev_bus;
  logic pin_out, pin_oe, cpu_reset, clk_stop, div4, abort, fetch;
  logic [15:0] vec;
  int n_fail, checked, cyc;

  mrs_reset_seq mrs_reset_seq_inst (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rst_pin_in(rst_pin_in), .por_det(por_det), .lowv_det(lowv_det),
    .wdog_overflow(ev_bus[0]), .bad_opcode(ev_bus[1]),
    .stop_exec(ev_bus[2]), .opcode_fetch(ev_bus[3]),
    .fetch_unmapped(ev_bus[4]), .data_read_unmapped(ev_bus[5]),
    .monitor_entry(ev_bus[6]), .monitor_mode(mon_mode),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .cpu_reset(cpu_reset),
    .clocks_stopped(clk_stop), .bus_div4_sel(div4), .abort_instr(abort),
    .fetch_start(fetch), .vector_addr(vec));
  mrs_pin_model mrs_pin_model_inst (.rst_pin_oe(pin_oe),
    .rst_pin_out(pin_out), .ext_hold(ext_hold), .rst_pin_in(rst_pin_in));

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Wait for pready; the hang guard bounds it
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge before any next setup
    @(posedge clk);
  endtask

  // Read the cause register and compare
  task automatic rd_cause(logic [31:0] exp);
    apb(1'b0, mrs_pkg::OFF_CAUSE, 32'h0);
    chk("cause", exp, rd);
    chk("cause pslverr", 32'h0, {31'h0, err});
  endtask

  // One-cycle CPU strobes
  task automatic ev(logic [6:0] m);
    ev_bus <= m;
    @(posedge clk);
    ev_bus <= 7'h00;
  endtask

  // Follow one reset to the vector fetch, counting each output's cycles
  task automatic run_reset(int e_cs, int full, int e_ab);
    int n_oe, n_hold, n_cs, n_div, n_ab, t;
    n_oe = 0;
    n_hold = 0;
    n_cs = 0;
    n_div = 0;
    n_ab = 0;
    t = 0;
    // First sample covers the cycle the triggering edge launched
    do
    begin
      #1;
      t++;
      n_oe += (pin_oe === 1'b1);
      n_hold += (cpu_reset === 1'b1);
      n_cs += (clk_stop === 1'b1);
      n_div += (div4 === 1'b1);
      n_ab += (abort === 1'b1);
      if (fetch !== 1'b1)
        @(posedge clk);
    end while (fetch !== 1'b1 && t < 9000);
    chk("fetch_start", 32'h1, {31'h0, fetch});
    if (e_cs >= 0) chk("stopped cycles", e_cs, n_cs);
    if (full) chk("pin low extra", 32, n_oe - n_cs);
    if (full) chk("hold extra", 32, n_hold - n_oe);
    chk("div4 cycles", n_hold, n_div);
    chk("aborts", e_ab, n_ab);
    @(posedge clk);
  endtask

  task automatic t_power();
    run_reset(4096, 1, 0);
    chk("vector", mrs_pkg::VEC_NORMAL, vec);
    rd_cause(32'h82);
    rd_cause(32'h00);
    $display("test power_on done");
  endtask

  task automatic t_wdog_accum();
    // Watchdog, bad opcode and unmapped fetch resets, flags left unread
    ev(7'h01);
    run_reset(0, 1, 1);
    ev(7'h02);
    run_reset(0, 1, 1);
    ev(7'h18);
    run_reset(0, 1, 1);
    rd_cause(32'h38);
    $display("test watchdog_opcode_address done");
  endtask

  task automatic t_stop_data();
    ev(7'h20);
    repeat (5) @(posedge clk);
    chk("no reset data read", 32'h0, {31'h0, cpu_reset});
    apb(1'b1, mrs_pkg::OFF_OPTION, 32'h1);
    ev(7'h04);
    repeat (5) @(posedge clk);
    chk("no reset stop ok", 32'h0, {31'h0, cpu_reset});
    apb(1'b1, mrs_pkg::OFF_OPTION, 32'h0);
    ev(7'h04);
    run_reset(0, 1, 1);
    rd_cause(32'h10);
    $display("test stop_data done");
  endtask

  task automatic t_mon_ext();
    int n;
    mon_mode <= 1'b1;
    ev(7'h40);
    run_reset(0, 1, 1);
    chk("vector", mrs_pkg::VEC_MONITOR, vec);
    mon_mode <= 1'b0;
    rd_cause(32'h04);
    // Abort comes while the pin is still held
    n = 0;
    ext_hold <= 1'b1;
    repeat (10)
    begin
      @(posedge clk);
      n += (abort === 1'b1);
    end
    ext_hold <= 1'b0;
    chk("ext abort", 32'h1, n);
    run_reset(0, 0, 0);
    rd_cause(32'h40);
    $display("test monitor_external done");
  endtask

  task automatic t_lowv_refuse();
    int n;
    // Abort comes while the supply is still low
    n = 0;
    lowv_det <= 1'b1;
    repeat (20)
    begin
      @(posedge clk);
      n += (abort === 1'b1);
    end
    lowv_det <= 1'b0;
    chk("lowv abort", 32'h1, n);
    run_reset(-1, 1, 0);
    rd_cause(32'h02);
    apb(1'b1, mrs_pkg::OFF_CAUSE, 32'hFF);
    chk("write cause err", 32'h1, {31'h0, err});
    apb(1'b0, 8'h0C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    rd_cause(32'h00);
    $display("test lowv_refuse done");
  endtask

  // Pin held past release, then power-on over a pending bad-opcode flag
  task automatic t_late_por();
    ext_hold <= 1'b1;
    ev(7'h01);
    run_reset(0, 1, 1);
    ext_hold <= 1'b0;
    rd_cause(32'h60);
    ev(7'h02);
    run_reset(0, 1, 1);
    // Detector edge passes the synchroniser first
    por_det <= 1'b1;
    repeat (3) @(posedge clk);
    run_reset(4096, 1, 1);
    por_det <= 1'b0;
    rd_cause(32'h82);
    $display("test late_pin_power_on done");
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    {srst, psel, penable, pwrite, por_det, lowv_det, ext_hold} = 7'h40;
    {paddr, pwdata, ev_bus, mon_mode} = '0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    t_power();
    t_wdog_accum();
    t_stop_data();
    t_mon_ext();
    t_lowv_refuse();
    t_late_por();
    give_verdict();
  end
endmodule // mcu_reset_sequencer_test

// file: sim/mrs_pin_model.sv
// Model of the reset pin node and of an outside device sharing it.
// Assumes an open-drain pin with a pull-up; any party may pull it low.
`timescale 1ns/1ps
module mrs_pin_model (
  // Sequencer drive
  input wire logic rst_pin_oe,
  input wire logic rst_pin_out,
  // Outside device pulling the pin low
  input wire logic ext_hold,
  // Resolved pin level
  output logic rst_pin_in
);
  // Wired-AND of every driver; pull-up when nobody pulls
  assign rst_pin_in = ((rst_pin_oe && !rst_pin_out) || ext_hold) ?
    1'b0 : 1'b1;
endmodule // mrs_pin_model

// file: src/mrs_cnt_if.sv
// Load and status signals between the sequencer and its counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface mrs_cnt_if;
  logic load;
  logic [12:0] load_val;
  logic zero;

  modport ctrl (output load, output load_val, input zero);
  modport cnt (input load, input load_val, output zero);
endinterface

// file: src/mrs_counter.sv
// Down counter timing each sequencer interval.
// Assumes load pulses on every state entry, with the interval minus one.
`timescale 1ns/1ps
module mrs_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Sequencer side
  mrs_cnt_if.cnt cif
);

  logic [12:0] value;

  // Load or count down to zero and hold
  always_ff @(posedge clk)
  begin
    if (srst)
      value <= mrs_pkg::STAB_CYC - 13'h0001;
    else if (cif.load)
      value <= cif.load_val;
    else if (value != 13'h0000)
      value <= value - 13'h0001;
  end

  assign cif.zero = (value == 13'h0000);

  load_takes_a: assert property (@(posedge clk) disable iff (srst)
    cif.load |=> value == $past(cif.load_val))
    else $error("Counter did not take its load value");

endmodule // mrs_counter

// file: src/mrs_pkg.sv
// Constants shared by the reset sequencer and its cycle counter.
// Assumes the crystal clock is the design clock, one tick per cycle.
package mrs_pkg;

  // Counter width covers the longest interval
  localparam int CNT_W = 13;

  // Interval lengths in crystal clock cycles
  localparam logic [12:0] STAB_CYC = 13'h1000;
  localparam logic [12:0] PIN_LOW_CYC = 13'h0020;
  localparam logic [12:0] POST_CYC = 13'h0020;
  // Least external low time before it counts as a reset
  localparam logic [3:0] EXT_MIN_LOW = 4'h4;

  // Reset vector addresses
  localparam logic [15:0] VEC_NORMAL = 16'hFFFE;
  localparam logic [15:0] VEC_MONITOR = 16'hFEFE;

  // Register byte offsets
  localparam logic [7:0] OFF_CAUSE = 8'h00;
  localparam logic [7:0] OFF_OPTION = 8'h04;
  localparam logic [7:0] OFF_STATE = 8'h08;

  // Cause flag bit positions
  localparam int BIT_POR = 7;
  localparam int BIT_PIN = 6;
  localparam int BIT_WDOG = 5;
  localparam int BIT_BADOP = 4;
  localparam int BIT_BADADR = 3;
  localparam int BIT_MON = 2;
  localparam int BIT_LOWV = 1;

  // Reset values
  localparam logic [7:0] CAUSE_RST = 8'h82;
  localparam logic STOP_EN_RST = 1'b0;

  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_RUN = 6'h01,
    ST_LOWV = 6'h02,
    ST_STAB = 6'h04,
    ST_PINLOW = 6'h08,
    ST_POST = 6'h10,
    ST_EXT = 6'h20
  } mrs_state_t;

endpackage

// file: src/mrs_reset_seq.sv
// Reset sequencer with reset-cause register on an APB slave port.
// Assumes clk is the crystal clock; CPU event strobes share its domain,
// while the reset pin and the analog detectors arrive asynchronously.
//
// Summary of operation
// - Any reset aborts, vector from FFFE or FEFE.
// - Bus clock is crystal over four during reset.
// - Pin held low long enough sets external flag.
// - Internal resets drive pin low 32 cycles.
// - Device stays in reset 32 more cycles.
// - Power-on stops clocks for 4096 cycles.
// - Power-on drives pin low through stabilisation, then more.
// - Pin released 32, CPU starts 64 after.
// - Power-on sets power-on and low-voltage, clears others.
// - Watchdog overflow resets, sets watchdog flag.
// - Low voltage holds pin, then 4096 plus release.
// - Low-voltage reset sets low-voltage flag.
// - Undefined opcode resets, sets bad-opcode flag.
// - Stop with stop disabled acts as bad opcode.
// - Opcode fetch from unmapped address resets, sets flag.
// - Data read from unmapped address never resets.
// - Cause register read-only, cleared by reading.
// - Pin still low 32 cycles after release sets external.
// - Flags accumulate until software reads them.
// - Monitor entry reset sets its own flag.
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/1ps
module mrs_reset_seq (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Asynchronous inputs: reset pin level and analog detectors
  input wire logic rst_pin_in,
  input wire logic por_det,
  input wire logic lowv_det,
  // CPU event strobes, same clock
  input wire logic wdog_overflow,
  input wire logic bad_opcode,
  input wire logic stop_exec,
  input wire logic opcode_fetch,
  input wire logic fetch_unmapped,
  input wire logic data_read_unmapped,
  input wire logic monitor_entry,
  input wire logic monitor_mode,
  // Reset pin drive, open drain
  output logic rst_pin_out,
  output logic rst_pin_oe,
  // Core control
  output logic cpu_reset,
  output logic clocks_stopped,
  output logic bus_div4_sel,
  output logic abort_instr,
  output logic fetch_start,
  output logic [15:0] vector_addr
);

  mrs_pkg::mrs_state_t state;
  mrs_pkg::mrs_state_t next_state;
  logic [7:0] cause;
  logic [7:0] set_bits;
  logic [7:0] next_cause;
  logic stop_enable;
  logic was_internal;
  logic [3:0] ext_low_cnt;
  logic [12:0] dwell_cnt;
  logic pin_m;
  logic pin_s;
  logic por_m;
  logic por_s;
  logic por_d;
  logic lowv_m;
  logic lowv_s;

  mrs_cnt_if cif ();

  mrs_counter u_counter (
    .clk(clk),
    .srst(srst),
    .cif(cif)
  );

  // Two-flop synchronisers for pin and detectors
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pin_m <= 1'b1;
      pin_s <= 1'b1;
      por_m <= 1'b0;
      por_s <= 1'b0;
      por_d <= 1'b0;
      lowv_m <= 1'b0;
      lowv_s <= 1'b0;
    end
    else
    begin
      pin_m <= rst_pin_in;
      pin_s <= pin_m;
      por_m <= por_det;
      por_s <= por_m;
      por_d <= por_s;
      lowv_m <= lowv_det;
      lowv_s <= lowv_m;
    end
  end

  // Event decode
  wire in_run = (state == mrs_pkg::ST_RUN);
  wire por_evt = por_s & ~por_d;
  wire lowv_evt = lowv_s & (state != mrs_pkg::ST_LOWV) & ~por_evt;
  wire stop_bad = stop_exec & ~stop_enable;
  wire badop_evt = in_run & (bad_opcode | stop_bad);
  wire badadr_evt = in_run & opcode_fetch & fetch_unmapped;
  wire wdog_evt = in_run & wdog_overflow;
  wire mon_evt = in_run & monitor_entry;
  // Data reads from unmapped space are deliberately not decoded
  wire int_evt = wdog_evt | badop_evt | badadr_evt | mon_evt;
  wire ext_evt = in_run & ~int_evt & (ext_low_cnt == mrs_pkg::EXT_MIN_LOW);
  wire post_end = (state == mrs_pkg::ST_POST) & cif.zero;
  wire pin_late = post_end & was_internal & ~pin_s;

  // Next-state selection
  always_comb
  begin
    next_state = state;
    if (por_evt)
      next_state = mrs_pkg::ST_STAB;
    else if (lowv_evt)
      next_state = mrs_pkg::ST_LOWV;
    else
    begin
      case (state)
        mrs_pkg::ST_RUN:
        begin
          if (int_evt)
            next_state = mrs_pkg::ST_PINLOW;
          else if (ext_evt)
            next_state = mrs_pkg::ST_EXT;
        end
        mrs_pkg::ST_LOWV:
          if (!lowv_s)
            next_state = mrs_pkg::ST_STAB;
        mrs_pkg::ST_STAB:
          if (cif.zero)
            next_state = mrs_pkg::ST_PINLOW;
        mrs_pkg::ST_PINLOW:
          if (cif.zero)
            next_state = mrs_pkg::ST_POST;
        mrs_pkg::ST_POST:
          if (cif.zero)
            next_state = mrs_pkg::ST_RUN;
        mrs_pkg::ST_EXT:
          if (pin_s)
            next_state = mrs_pkg::ST_POST;
        default:
          next_state = mrs_pkg::ST_STAB;
      endcase
    end
  end

  // Interval load on every state entry or power-on restart
  assign cif.load = (next_state != state) | por_evt;
  assign cif.load_val = (next_state == mrs_pkg::ST_STAB) ?
    mrs_pkg::STAB_CYC - 13'h0001 :
    (next_state == mrs_pkg::ST_PINLOW) ?
    mrs_pkg::PIN_LOW_CYC - 13'h0001 :
    mrs_pkg::POST_CYC - 13'h0001;

  // State register
  always_ff @(posedge clk)
  begin
    if (srst)
      state <= mrs_pkg::ST_STAB;
    else
      state <= next_state;
  end

  // Cycles spent in the current state
  always_ff @(posedge clk)
  begin
    if (srst || cif.load)
      dwell_cnt <= 13'h0000;
    else
      dwell_cnt <= dwell_cnt + 13'h0001;
  end

  // External low time, counted only while the pin is not driven here
  always_ff @(posedge clk)
  begin
    if (srst || pin_s || !in_run)
      ext_low_cnt <= 4'h0;
    else if (ext_low_cnt != mrs_pkg::EXT_MIN_LOW)
      ext_low_cnt <= ext_low_cnt + 4'h1;
  end

  // Remembers whether the sequence drove the pin itself
  always_ff @(posedge clk)
  begin
    if (srst)
      was_internal <= 1'b1;
    else if (next_state == mrs_pkg::ST_PINLOW)
      was_internal <= 1'b1;
    else if (next_state == mrs_pkg::ST_EXT)
      was_internal <= 1'b0;
  end

  // APB decode, zero wait states
  wire apb_acc = psel & penable;
  wire hit_cause = (paddr == mrs_pkg::OFF_CAUSE);
  wire hit_option = (paddr == mrs_pkg::OFF_OPTION);
  wire hit_state = (paddr == mrs_pkg::OFF_STATE);
  wire hit_any = hit_cause | hit_option | hit_state;
  wire rd_clr = apb_acc & ~pwrite & hit_cause;
  wire wr_option = apb_acc & pwrite & hit_option;
  assign pready = 1'b1;
  assign pslverr = apb_acc & (~hit_any | (pwrite & ~hit_option));

  // Cause bits raised this cycle
  assign set_bits = {1'b0,
    ext_evt | pin_late,
    wdog_evt,
    badop_evt,
    badadr_evt,
    mon_evt,
    lowv_evt,
    1'b0};

  // Set wins over the read clear; flags pile up between reads
  assign next_cause = por_evt ? mrs_pkg::CAUSE_RST :
    ((rd_clr ? 8'h00 : cause) | set_bits);

  // Cause register, eight bits at fixed positions
  always_ff @(posedge clk)
  begin
    if (srst)
      cause <= mrs_pkg::CAUSE_RST;
    else
      cause <= next_cause;
  end

  // Option register, stop enable in bit 0
  always_ff @(posedge clk)
  begin
    if (srst)
      stop_enable <= mrs_pkg::STOP_EN_RST;
    else if (wr_option)
      stop_enable <= pwdata[0];
  end

  // Read data latched in the setup phase of the same read
  wire [31:0] rd_mux = hit_cause ? {24'h000000, cause} :
    hit_option ? {31'h00000000, stop_enable} :
    hit_state ? {26'h0000000, state} : 32'h00000000;

  always_ff @(posedge clk)
  begin
    if (srst)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  // Registered core and pin controls
  wire nx_run = (next_state == mrs_pkg::ST_RUN);
  wire nx_drive = (next_state == mrs_pkg::ST_LOWV) |
    (next_state == mrs_pkg::ST_STAB) | (next_state == mrs_pkg::ST_PINLOW);
  wire nx_stop = (next_state == mrs_pkg::ST_LOWV) |
    (next_state == mrs_pkg::ST_STAB);

  assign rst_pin_out = 1'b0;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rst_pin_oe <= 1'b1;
      cpu_reset <= 1'b1;
      clocks_stopped <= 1'b1;
      bus_div4_sel <= 1'b1;
      abort_instr <= 1'b0;
      fetch_start <= 1'b0;
      vector_addr <= mrs_pkg::VEC_NORMAL;
    end
    else
    begin
      rst_pin_oe <= nx_drive;
      cpu_reset <= ~nx_run;
      clocks_stopped <= nx_stop;
      bus_div4_sel <= ~nx_run;
      abort_instr <= in_run & ~nx_run;
      fetch_start <= post_end & ~por_evt & ~lowv_evt;
      vector_addr <= monitor_mode ? mrs_pkg::VEC_MONITOR :
        mrs_pkg::VEC_NORMAL;
    end
  end

  pin_low_len_a: assert property (@(posedge clk) disable iff (srst)
    (state == mrs_pkg::ST_PINLOW && next_state == mrs_pkg::ST_POST)
    |-> dwell_cnt == mrs_pkg::PIN_LOW_CYC - 13'h0001)
    else $error("Pin low interval has wrong length");

  post_hold_len_a: assert property (@(posedge clk) disable iff (srst)
    (state == mrs_pkg::ST_POST && next_state == mrs_pkg::ST_RUN)
    |-> dwell_cnt == mrs_pkg::POST_CYC - 13'h0001)
    else $error("Post release hold has wrong length");

  stab_delay_len_a: assert property (@(posedge clk) disable iff (srst)
    (state == mrs_pkg::ST_STAB && next_state == mrs_pkg::ST_PINLOW)
    |-> dwell_cnt == mrs_pkg::STAB_CYC - 13'h0001)
    else $error("Stabilisation delay has wrong length");

  drive_during_hold_a: assert property (@(posedge clk) disable iff (srst)
    (state inside {mrs_pkg::ST_STAB, mrs_pkg::ST_LOWV})
    |-> rst_pin_oe && clocks_stopped && cpu_reset && bus_div4_sel)
    else $error("Pin or clocks released during stabilisation");

  por_flags_a: assert property (@(posedge clk) disable iff (srst)
    por_evt |=> cause == mrs_pkg::CAUSE_RST)
    else $error("Power-on did not leave only its own flags");

  read_clears_a: assert property (@(posedge clk) disable iff (srst)
    (rd_clr && set_bits == 8'h00 && !por_evt) |=> cause == 8'h00)
    else $error("Reading the cause register did not clear it");

  data_read_safe_a: assert property (@(posedge clk) disable iff (srst)
    (in_run && data_read_unmapped && !int_evt && !ext_evt
    && !por_evt && !lowv_evt) |=> state == mrs_pkg::ST_RUN)
    else $error("Unmapped data read caused a reset");

  stop_illegal_a: assert property (@(posedge clk) disable iff (srst)
    (in_run && stop_exec && !stop_enable && !por_evt && !lowv_evt)
    |=> state == mrs_pkg::ST_PINLOW && cause[mrs_pkg::BIT_BADOP])
    else $error("Disabled stop did not reset as bad opcode");

  late_pin_flag_a: assert property (@(posedge clk) disable iff (srst)
    (pin_late && !por_evt) |=> cause[mrs_pkg::BIT_PIN])
    else $error("Low pin after release did not set external flag");

  vector_sel_a: assert property (@(posedge clk) disable iff (srst)
    fetch_start |-> vector_addr == ($past(monitor_mode) ?
    mrs_pkg::VEC_MONITOR : mrs_pkg::VEC_NORMAL))
    else $error("Wrong reset vector at fetch start");

endmodule // mrs_reset_seq
